/* File: core/bcm_core.sv */
// Decode and execute core for branches, long call/jump and byte/bit moves
`timescale 1ns/1ps
// Notes on behaviour
// RULE_01 - Branch-if-nonzero: two bytes, pc plus two, add offset if accumulator nonzero.
// RULE_02 - Branch-if-zero: two bytes, pc plus two, add offset if accumulator zero.
// RULE_03 - Offset is signed, added to advanced pc; accumulator and flags unchanged.
// RULE_04 - Long call: pc plus three, push low then high byte, pre-incrementing stack.
// RULE_05 - Long call then loads pc high from byte two, low from byte three.
// RULE_06 - Long jump: three bytes, two cycles, loads pc from bytes two and three.
// RULE_07 - Byte moves copy source to destination, nothing else changes.
// RULE_08 - Register/accumulator forms one byte one cycle; immediate-to-register two bytes.
// RULE_09 - Direct to/from accumulator: two bytes, one cycle, byte two is address.
// RULE_10 - Direct-to-direct: three bytes, two cycles, source address first.
// RULE_11 - Direct move of accumulator into itself is invalid, result undefined.
// RULE_12 - Indirect forms use selected pointer register content as address.
// RULE_13 - Immediate loads: to accumulator, to direct (address first), to indirect.
// RULE_14 - Register or indirect into direct, and direct into register, are two bytes.
// RULE_15 - Bit moves between carry and any addressable bit; one operand is carry.
// RULE_16 - Pointer load: byte two to high byte, byte three to low byte.
// RULE_17 - Code read at accumulator plus 16-bit base, full carry, into accumulator.
// RULE_18 - Program counter base is the next instruction; data pointer not altered.
// RULE_19 - Low three bits pick working register in bank; low bit picks pointer.
module bcm_core (
  input  wire logic              clk_sys,    // System clock, 200 MHz
  input  wire logic              rst_n,      // Synchronous reset, active low
  output bcm_pkg::bcm_arch_s     arch,       // Architectural registers
  output logic [15:0]            code_addr,  // Program memory address
  input  wire logic [7:0]        code_data,  // Program memory data at code_addr
  output logic                   instr_done, // Pulse as an instruction retires
  output logic [1:0]             instr_cyc,  // Documented cycle count of it
  output logic                   illegal_op  // Pulse on invalid or foreign opcode
);
  import bcm_pkg::*;

  // ****************************************************************
  // State
  // ****************************************************************
  bcm_state_e  state, next_state;
  bcm_arch_s   next_arch;
  logic [7:0]  opcode, next_opcode;
  logic [7:0]  b2, next_b2;
  logic [7:0]  b3, next_b3;
  logic [15:0] next_code_addr;
  logic        next_instr_done;
  logic [1:0]  next_instr_cyc;
  logic        next_illegal_op;

  bcm_dec_s    dec_op;
  bcm_wr_s     ram_wr;
  logic [7:0]  rd_a_addr, rd_a_data, rd_b_addr, rd_b_data;
  logic [7:0]  rn_addr, ri_addr, bit_byte_addr;
  logic [2:0]  bit_pos;
  logic [7:0]  src, bit_byte, bit_new;
  logic [15:0] branch_target, code_sum;

  // ****************************************************************
  // Data RAM
  // ****************************************************************
  bcm_data_ram u_ram (
    .clk_sys   (clk_sys),
    .rst_n     (rst_n),
    .wr        (ram_wr),
    .rd_a_addr (rd_a_addr),
    .rd_a_data (rd_a_data),
    .rd_b_addr (rd_b_addr),
    .rd_b_data (rd_b_data)
  );

  // Direct-space read: core registers shadow their RAM locations
  function automatic logic [7:0] rd_dir(input logic [7:0] a, input bcm_arch_s r,
                                        input logic [7:0] ram);
    logic [7:0] v;
    v = ram;
    case (a)
      ADDR_ACC: v = r.acc;
      ADDR_PSW: v = r.psw;
      ADDR_SP:  v = r.sp;
      ADDR_DP_LO: v = r.ptr16[7:0];
      ADDR_DP_HI: v = r.ptr16[15:8];
      default:  v = ram;
    endcase
    return v;
  endfunction : rd_dir

  // ****************************************************************
  // Operand addressing
  // ****************************************************************
  // Register selection uses the active bank from the status byte
  always_comb begin
    dec_op        = bcm_decode(opcode);
    rn_addr       = {3'b000, arch.psw[PSW_RS1], arch.psw[PSW_RS0], opcode[2:0]}; // [RULE_19]
    ri_addr       = {3'b000, arch.psw[PSW_RS1], arch.psw[PSW_RS0], 2'b00, opcode[0]}; // [RULE_19]
    rd_b_addr     = ri_addr;                                              // [RULE_12]
    bit_pos       = b2[2:0];
    bit_byte_addr = b2[7] ? {b2[7:3], 3'b000} : (BIT_AREA + {4'h0, b2[6:3]});
    // Port A serves working register, indirect, bit byte or direct source
    casez (opcode)
      8'b1110_1???:                         rd_a_addr = rn_addr;
      8'b1110_011?, 8'b1000_011?,
      8'b1111_011?, 8'b0111_011?:           rd_a_addr = rd_b_data;        // [RULE_12]
      8'b1000_1???:                         rd_a_addr = rn_addr;
      OP_C_BIT, OP_BIT_C:                   rd_a_addr = bit_byte_addr;
      default:                              rd_a_addr = b2;               // [RULE_10]
    endcase
    bit_byte      = rd_dir(bit_byte_addr, arch, rd_a_data);
    bit_new       = bit_byte;
    bit_new[bit_pos] = arch.psw[PSW_CY];                                  // [RULE_15]
    // Offset is sign extended; pc already points past the branch
    branch_target = arch.pc + {{8{b2[7]}}, b2};                           // [RULE_03]
    // Base register plus unsigned accumulator, full 16-bit carry
    code_sum      = ((opcode == OP_CR_PC) ? arch.pc : arch.ptr16)
                    + {8'h00, arch.acc};                                  // [RULE_17] [RULE_18]
  end

  // ****************************************************************
  // Source byte of a byte move
  // ****************************************************************
  always_comb begin
    casez (opcode)
      8'b1110_1???, 8'b1110_011?,
      8'b1000_011?, 8'b1000_1???:           src = rd_a_data;              // [RULE_08]
      8'b1111_1???, 8'b1111_011?, OP_DIR_A: src = arch.acc;               // [RULE_09]
      OP_A_IMM, 8'b0111_1???, 8'b0111_011?: src = b2;                     // [RULE_13]
      OP_DIR_IMM:                           src = b3;                     // [RULE_13]
      default:                              src = rd_dir(b2, arch, rd_a_data);
    endcase
  end

  // ****************************************************************
  // Sequencer and execution
  // ****************************************************************
  // One process computes every next value; writes into the direct
  // space go to a core register when the address aliases one of them,
  // otherwise to the RAM write port.
  always_comb begin
    logic       dir_we;
    logic [7:0] dir_addr;
    logic [7:0] dir_data;
    dir_we          = 1'b0;
    dir_addr        = b2;
    dir_data        = src;
    next_state      = state;
    next_arch       = arch;
    next_opcode     = opcode;
    next_b2         = b2;
    next_b3         = b3;
    next_code_addr  = code_addr;
    next_instr_done = 1'b0;
    next_instr_cyc  = instr_cyc;
    next_illegal_op = 1'b0;
    ram_wr          = '{en: 1'b0, addr: b2, data: src};
    case (state)
      ST_OP: begin
        // Opcode byte: each byte fetched advances pc by one
        next_opcode    = code_data;
        next_arch.pc   = arch.pc + 16'h0001;
        next_code_addr = arch.pc + 16'h0001;
        next_state     = (bcm_decode(code_data).len == 2'd1) ? ST_EX : ST_B2;
      end
      ST_B2: begin
        next_b2        = code_data;
        next_arch.pc   = arch.pc + 16'h0001;
        next_code_addr = arch.pc + 16'h0001;
        next_state     = (dec_op.len == 2'd3) ? ST_B3 : ST_EX;
      end
      ST_B3: begin
        next_b3        = code_data;
        next_arch.pc   = arch.pc + 16'h0001;
        next_code_addr = arch.pc + 16'h0001;
        next_state     = ST_EX;
      end
      ST_EX: begin
        next_state      = ST_OP;
        next_instr_done = 1'b1;
        next_instr_cyc  = dec_op.cyc;
        next_illegal_op = !dec_op.valid;
        casez (opcode)
          OP_BNZ: if (arch.acc != 8'h00) next_arch.pc = branch_target;    // [RULE_01]
          OP_BZ:  if (arch.acc == 8'h00) next_arch.pc = branch_target;    // [RULE_02]
          OP_LONG_CALL: begin
            // First push: return address low byte, stack pre-incremented
            next_arch.sp    = arch.sp + 8'h01;                            // [RULE_04]
            ram_wr          = '{en: 1'b1, addr: arch.sp + 8'h01, data: arch.pc[7:0]};
            next_state      = ST_EX2;
            next_instr_done = 1'b0;
          end
          OP_LONG_JUMP: next_arch.pc = {b2, b3};                          // [RULE_06]
          OP_A_DIR: begin
            next_arch.acc   = src;                                        // [RULE_09]
            next_illegal_op = (b2 == ADDR_ACC);                           // [RULE_11]
          end
          8'b1110_1???, 8'b1110_011?, OP_A_IMM:
            next_arch.acc = src;                                          // [RULE_07]
          8'b1111_1???, 8'b0111_1???, 8'b1010_1???:
            ram_wr = '{en: 1'b1, addr: rn_addr, data: src};               // [RULE_08] [RULE_14]
          8'b1111_011?, 8'b0111_011?, 8'b1010_011?:
            ram_wr = '{en: 1'b1, addr: rd_b_data, data: src};             // [RULE_12]
          OP_DIR_A, 8'b1000_1???, 8'b1000_011?: dir_we = 1'b1;            // [RULE_14]
          OP_DIR_DIR: begin
            dir_we   = 1'b1;
            dir_addr = b3;                                                // [RULE_10]
          end
          OP_DIR_IMM: dir_we = 1'b1;                                      // [RULE_13]
          OP_C_BIT:  next_arch.psw[PSW_CY] = bit_byte[bit_pos];           // [RULE_15]
          OP_BIT_C: begin
            dir_we   = 1'b1;
            dir_addr = bit_byte_addr;
            dir_data = bit_new;                                           // [RULE_15]
          end
          OP_DP_IMM: next_arch.ptr16 = {b2, b3};                          // [RULE_16]
          OP_CR_DP, OP_CR_PC: begin
            // Table read needs the code port for one more cycle
            next_code_addr  = code_sum;                                   // [RULE_17]
            next_state      = ST_EX2;
            next_instr_done = 1'b0;
          end
          default: next_arch = arch;
        endcase
        // Count changes only with the retire pulse; two-phase ops set it later
        if (!next_instr_done) next_instr_cyc = instr_cyc;
        if (next_state == ST_OP) next_code_addr = next_arch.pc;
      end
      ST_EX2: begin
        next_state      = ST_OP;
        next_instr_done = 1'b1;
        next_instr_cyc  = dec_op.cyc;
        if (opcode == OP_LONG_CALL) begin
          // Second push: high byte, then jump anywhere in 64 Kbyte
          next_arch.sp = arch.sp + 8'h01;                                 // [RULE_04]
          ram_wr       = '{en: 1'b1, addr: arch.sp + 8'h01, data: arch.pc[15:8]};
          next_arch.pc = {b2, b3};                                        // [RULE_05]
        end else begin
          next_arch.acc = code_data;                                      // [RULE_17]
        end
        next_code_addr = next_arch.pc;
      end
      default: next_state = ST_OP;
    endcase
    // Direct-space write with register aliasing
    if (dir_we) begin
      case (dir_addr)
        ADDR_ACC: next_arch.acc        = dir_data;
        ADDR_PSW: next_arch.psw        = dir_data;
        ADDR_SP:  next_arch.sp         = dir_data;
        ADDR_DP_LO: next_arch.ptr16[7:0]  = dir_data;
        ADDR_DP_HI: next_arch.ptr16[15:8] = dir_data;
        default:  ram_wr = '{en: 1'b1, addr: dir_addr, data: dir_data};   // [RULE_07]
      endcase
    end
  end

  // ****************************************************************
  // Registers
  // ****************************************************************
  // Memory contents are not cleared by a core reset beyond the RAM's own
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      state      <= ST_OP;
      arch       <= '{pc: RST_PC, acc: RST_BYTE, sp: RST_SP,
                      ptr16: {RST_BYTE, RST_BYTE}, psw: RST_BYTE};
      opcode     <= RST_BYTE;
      b2         <= RST_BYTE;
      b3         <= RST_BYTE;
      code_addr  <= RST_PC;
      instr_done <= 1'b0;
      instr_cyc  <= 2'd0;
      illegal_op <= 1'b0;
    end else begin
      state      <= next_state;
      arch       <= next_arch;
      opcode     <= next_opcode;
      b2         <= next_b2;
      b3         <= next_b3;
      code_addr  <= next_code_addr;
      instr_done <= next_instr_done;
      instr_cyc  <= next_instr_cyc;
      illegal_op <= next_illegal_op;
    end
  end

endmodule : bcm_core

/* File: core/bcm_data_ram.sv */
// Internal data RAM: flip-flop array, one write port, two read ports
`timescale 1ns/1ps
module bcm_data_ram (
  input  wire logic             clk_sys,  // System clock
  input  wire logic             rst_n,    // Synchronous reset, active low
  input  wire bcm_pkg::bcm_wr_s wr,       // Write request
  input  wire logic [7:0]       rd_a_addr,// Read port A address
  output logic [7:0]            rd_a_data,// Read port A data
  input  wire logic [7:0]       rd_b_addr,// Read port B address
  output logic [7:0]            rd_b_data // Read port B data
);
  import bcm_pkg::*;

  logic [7:0] mem [RAM_DEPTH];

  // ****************************************************************
  // Storage, one byte per entry
  // ****************************************************************
  for (genvar g = 0; g < RAM_DEPTH; g++) begin : g_byte
    logic [7:0] next_byte;
    // Hold unless this entry is addressed by the write port
    always_comb begin
      next_byte = (wr.en && wr.addr == 8'(g)) ? wr.data : mem[g];
    end
    always_ff @(posedge clk_sys) begin
      if (!rst_n) mem[g] <= RST_BYTE;
      else        mem[g] <= next_byte;
    end
  end

  // Reads are combinational so indirect reads can chain in one cycle
  assign rd_a_data = mem[rd_a_addr];
  assign rd_b_data = mem[rd_b_addr];

endmodule : bcm_data_ram

/* File: shared/bcm_pkg.sv */
// Shared constants, types and opcode tables for the branch/call/move slice
package bcm_pkg;

  // ****************************************************************
  // Widths and special byte addresses
  // ****************************************************************
  localparam int unsigned RAM_DEPTH = 256;
  // Direct addresses of core registers that alias into the direct space
  localparam logic [7:0] ADDR_ACC  = 8'he0;
  localparam logic [7:0] ADDR_PSW  = 8'hd0;
  localparam logic [7:0] ADDR_SP   = 8'h81;
  localparam logic [7:0] ADDR_DP_LO = 8'h82;
  localparam logic [7:0] ADDR_DP_HI = 8'h83;
  // Bit-addressable byte area base for bit addresses below the SFR half
  localparam logic [7:0] BIT_AREA  = 8'h20;
  localparam int unsigned PSW_CY   = 7;
  localparam int unsigned PSW_RS1  = 4;
  localparam int unsigned PSW_RS0  = 3;

  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic [15:0] RST_PC   = 16'h0000;
  localparam logic [7:0]  RST_SP   = 8'h07;
  localparam logic [7:0]  RST_BYTE = 8'h00;

  // ****************************************************************
  // Opcodes (fixed ones; r and i forms are matched by casez)
  // ****************************************************************
  localparam logic [7:0] OP_BNZ    = 8'h70;
  localparam logic [7:0] OP_BZ     = 8'h60;
  localparam logic [7:0] OP_LONG_CALL = 8'h12;
  localparam logic [7:0] OP_LONG_JUMP = 8'h02;
  localparam logic [7:0] OP_A_DIR  = 8'he5;
  localparam logic [7:0] OP_DIR_A  = 8'hf5;
  localparam logic [7:0] OP_DIR_DIR= 8'h85;
  localparam logic [7:0] OP_A_IMM  = 8'h74;
  localparam logic [7:0] OP_DIR_IMM= 8'h75;
  localparam logic [7:0] OP_C_BIT  = 8'ha2;
  localparam logic [7:0] OP_BIT_C  = 8'h92;
  localparam logic [7:0] OP_DP_IMM = 8'h90;
  localparam logic [7:0] OP_CR_DP  = 8'h93;
  localparam logic [7:0] OP_CR_PC  = 8'h83;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef enum logic [2:0] {
    ST_OP  = 3'b000,
    ST_B2  = 3'b001,
    ST_B3  = 3'b010,
    ST_EX  = 3'b011,
    ST_EX2 = 3'b100
  } bcm_state_e;

  typedef struct packed {
    logic        valid;
    logic [1:0]  len;
    logic [1:0]  cyc;
  } bcm_dec_s;

  typedef struct packed {
    logic [15:0] pc;
    logic [7:0]  acc;
    logic [7:0]  sp;
    logic [15:0] ptr16;
    logic [7:0]  psw;
  } bcm_arch_s;

  typedef struct packed {
    logic        en;
    logic [7:0]  addr;
    logic [7:0]  data;
  } bcm_wr_s;

  // Byte count and cycle count per opcode; invalid outside this slice
  function automatic bcm_dec_s bcm_decode(input logic [7:0] op);
    bcm_dec_s d;
    d = '{valid: 1'b1, len: 2'd2, cyc: 2'd1};
    casez (op)
      8'h70, 8'h60:                 d.cyc = 2'd2;
      8'h12, 8'h02, 8'h85, 8'h75,
      8'h90:                        d = '{valid: 1'b1, len: 2'd3, cyc: 2'd2};
      8'b1110_1???, 8'b1111_1???,
      8'b1110_011?, 8'b1111_011?:   d.len = 2'd1;
      8'he5, 8'hf5, 8'h74, 8'ha2,
      8'b0111_1???, 8'b0111_011?:   d.cyc = 2'd1;
      8'b1010_1???, 8'b1000_1???,
      8'b1000_011?, 8'b1010_011?,
      8'h92:                        d.cyc = 2'd2;
      8'h93, 8'h83:                 d = '{valid: 1'b1, len: 2'd1, cyc: 2'd2};
      default:                      d = '{valid: 1'b0, len: 2'd1, cyc: 2'd1};
    endcase
    return d;
  endfunction : bcm_decode

endpackage : bcm_pkg

/* File: verif/bcm_core_monitor.sv */
// Concurrent checks on the ports of the branch, call and move core
`timescale 1ns/1ps
module bcm_core_monitor (
  input wire logic               clk_sys,    // System clock
  input wire logic               rst_n,      // Synchronous reset, active low
  input wire bcm_pkg::bcm_arch_s arch,       // Architectural registers
  input wire logic [15:0]        code_addr,  // Program memory address
  input wire logic [7:0]         code_data,  // Program memory byte
  input wire logic               instr_done, // Retire pulse
  input wire logic [1:0]         instr_cyc,  // Documented cycle count
  input wire logic               illegal_op  // Foreign opcode pulse
);
  import bcm_pkg::*;
  logic [2:0] gap;
  logic [2:0] next_gap;
  logic       seen;
  logic       next_seen;

  // ****************************************************************
  // Retirement spacing helper
  // ****************************************************************
  // Saturating, so a stalled core never wraps back into a legal spacing
  always_comb begin
    next_gap  = instr_done ? 3'h1 : ((gap == 3'h7) ? gap : gap + 3'h1);
    next_seen = seen | instr_done;
  end
  // Counter is meaningless before the first retirement, hence the seen flag
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      gap  <= 3'h0;
      seen <= 1'b0;
    end else begin
      gap  <= next_gap;
      seen <= next_seen;
    end
  end

  default clocking @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);

  chk_reset_image: assert property ($rose(rst_n) |-> arch == {RST_PC, RST_BYTE, RST_SP,
      16'h0000, RST_BYTE} && code_addr == RST_PC && !instr_done)
    else $error("core state after reset differs from the reset image");
  chk_done_pulse: assert property (instr_done |=> !instr_done)
    else $error("retire pulse lasted more than one cycle");
  chk_retire_bound: assert property (instr_done |-> ##[2:5] instr_done)
    else $error("next instruction did not retire in time");
  chk_illegal_flag: assert property (illegal_op |-> instr_done && instr_cyc == 2'h1)
    else $error("foreign opcode flag without a one-cycle retirement");
  chk_cyc_hold: assert property (!instr_done |-> $stable(instr_cyc))
    else $error("cycle count moved between retirements");
  chk_one_cycle: assert property (instr_done && seen && instr_cyc == 2'h1
      |-> gap inside {3'h2, 3'h3})
    else $error("one-cycle instruction took the wrong wall time");
  chk_two_cycle: assert property (instr_done && seen && instr_cyc == 2'h2
      |-> gap inside {3'h3, 3'h4, 3'h5})
    else $error("two-cycle instruction took the wrong wall time");
  chk_illegal_acc: assert property (illegal_op |-> arch.acc == $past(arch.acc))
    else $error("accumulator changed across a foreign opcode");
endmodule : bcm_core_monitor

/* File: verif/bcm_prog_rom.sv */
// Program memory model with a bench-side byte load port
`timescale 1ns/1ps
module bcm_prog_rom (
  input  wire logic        clk_sys,   // System clock
  input  wire logic        wr_en,     // Load strobe
  input  wire logic [15:0] wr_addr,   // Load address
  input  wire logic [7:0]  wr_data,   // Load byte
  input  wire logic [15:0] code_addr, // Fetch address from the core
  output logic [7:0]       code_data  // Byte at the fetch address
);
  logic [7:0] mem [0:65535];
  // Unloaded places read unknown, so a stray fetch shows up at once
  always @(posedge clk_sys) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end
  // No wait states: the core samples the byte on the same edge
  assign code_data = mem[code_addr];
endmodule : bcm_prog_rom

/* File: verif/testbench.sv */
// Self-checking bench for the branch, call and move core
`timescale 1ns/1ps
module testbench;
  import bcm_pkg::*;
  logic        clk_sys;
  logic        rst_n;
  bcm_arch_s   arch;
  logic [15:0] code_addr;
  logic [7:0]  code_data;
  logic        instr_done;
  logic [1:0]  instr_cyc;
  logic        illegal_op;
  logic        wr_en;
  logic [15:0] wr_addr;
  logic [7:0]  wr_data;
  logic [7:0]  prog [$];
  int          error_cnt;
  int          n_tests;
  int          ill;

  // ****************************************************************
  // Clock, core and program memory
  // ****************************************************************
  initial clk_sys = 1'b0;
  always #2.5 clk_sys = ~clk_sys;

  bcm_core i_bcm_core (.clk_sys(clk_sys), .rst_n(rst_n), .arch(arch), .code_addr(code_addr),
    .code_data(code_data), .instr_done(instr_done), .instr_cyc(instr_cyc),
    .illegal_op(illegal_op));
  bcm_prog_rom i_bcm_prog_rom (.clk_sys(clk_sys), .wr_en(wr_en), .wr_addr(wr_addr),
    .wr_data(wr_data), .code_addr(code_addr), .code_data(code_data));

  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    n_tests++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  // Loads only under reset, so no fetch ever sees a half-written program
  task automatic load(input logic [15:0] base);
    foreach (prog[k]) begin
      @(negedge clk_sys);
      rst_n   = 1'b0;
      wr_en   = 1'b1;
      wr_addr = base + 16'(k);
      wr_data = prog[k];
    end
    @(negedge clk_sys);
    wr_en = 1'b0;
  endtask : load

  // Reset image, release, then count retirements under a cycle bound
  task automatic release_run(input int n);
    int k;
    int t;
    k   = 0;
    t   = 0;
    ill = 0;
    repeat (6) @(negedge clk_sys);
    check(64'(arch), 64'({RST_PC, RST_BYTE, RST_SP, 16'h0000, RST_BYTE}));
    check(64'(code_addr), 64'(RST_PC));
    rst_n = 1'b1;
    while (k < n && t < 300) begin
      @(negedge clk_sys);
      t++;
      if (instr_done === 1'b1) k++;
      if (illegal_op === 1'b1) ill++;
    end
    check(64'(k), 64'(n));
    repeat (10) @(negedge clk_sys);
  endtask : release_run

  // Taken and untaken branches both ways; wrong paths fall into a trap loop
  task automatic test_branches();
    prog = {8'h74, 8'h00, 8'h70, 8'hfc, 8'h60, 8'h03, 8'h02, 8'h00, 8'hf0, 8'h74, 8'h81,
            8'h60, 8'hf9, 8'h70, 8'h03, 8'h02, 8'h00, 8'hf0, 8'he5, 8'he0, 8'h70, 8'hfc};
    load(16'h0000);
    prog = {8'h74, 8'hee, 8'h02, 8'h00, 8'hf2};
    load(16'h00f0);
    release_run(8);
    check(64'(arch.acc), 64'h81);
    check(64'(arch.psw), 64'h00);
    check(64'(ill != 0), 64'h1);
  endtask : test_branches

  // Call pushes, code reads with carry into the high byte, pointer load
  task automatic test_call_code();
    prog = {8'h02, 8'h01, 8'h00};
    load(16'h0000);
    prog = {8'h12, 8'h12, 8'h34};
    load(16'h0100);
    prog = {8'h90, 8'h02, 8'hfe, 8'h85, 8'h08, 8'h83, 8'h74, 8'h02, 8'h93, 8'h83,
            8'h78, 8'h09, 8'h86, 8'h82, 8'h02, 8'h12, 8'h42};
    load(16'h1234);
    prog = {8'h5a};
    load(16'h0400);
    prog = {8'hc3};
    load(16'h1298);
    release_run(9);
    check(64'({arch.acc, arch.sp, arch.ptr16, arch.psw}),
          64'hc3_09_0301_00);
    check(64'(arch.sp), 64'h09);
    check(64'(ill), 64'h0);
  endtask : test_call_code

  // Bank 1 registers, indirect, immediate, direct and bit moves
  task automatic test_moves();
    prog = {8'h75, 8'hd0, 8'h08, 8'h79, 8'h44, 8'h77, 8'h99, 8'he7, 8'hfb, 8'h74, 8'h00,
            8'heb, 8'ha2, 8'he7, 8'h92, 8'h03, 8'h8b, 8'h82, 8'he5, 8'h20, 8'h85, 8'h0b,
            8'h83, 8'h74, 8'h5c, 8'hf6, 8'ha7, 8'h20, 8'hf5, 8'h30, 8'hae, 8'h30, 8'he7,
            8'h8e, 8'h83, 8'h85, 8'h00, 8'h82, 8'h02, 8'h00, 8'h26};
    load(16'h0000);
    release_run(20);
    check(64'({arch.acc, arch.ptr16}), 64'h08_5c5c);
    check(64'({arch.psw, arch.sp}), 64'h88_07);
    check(64'(ill), 64'h0);
  endtask : test_moves

  task automatic conclude();
    $display("Comparisons %0d, mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : conclude

  // Main sequence
  initial begin
    rst_n     = 1'b0;
    wr_en     = 1'b0;
    wr_addr   = 16'h0000;
    wr_data   = 8'h00;
    error_cnt = 0;
    n_tests   = 0;
    test_branches();
    test_call_code();
    test_moves();
    conclude();
  end

  // The run needs well under a thousand cycles; this bound leaves ample margin
  initial begin
    repeat (20000) @(posedge clk_sys);
    error_cnt++;
    conclude();
  end
endmodule : testbench

bind bcm_core bcm_core_monitor i_bcm_core_monitor (.clk_sys(clk_sys), .rst_n(rst_n),
  .arch(arch), .code_addr(code_addr), .code_data(code_data), .instr_done(instr_done),
  .instr_cyc(instr_cyc), .illegal_op(illegal_op));
